// file: audio_clock_pkg.sv
// Package with the register map, field layout and types of the audio serial clock unit.
package audio_clock_pkg;

    // Register byte offsets.
    localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET = 4'h4;

    // Control register field positions.
    localparam int MASTER_OUT_INV_BIT   = 31;
    localparam int SERIAL_OUT_INV_BIT   = 30;
    localparam int FRAME_OUT_INV_BIT    = 29;
    localparam int MASTER_DIV_MSB       = 28;
    localparam int MASTER_DIV_LSB       = 24;
    localparam int SERIAL_DIV_MSB       = 23;
    localparam int SERIAL_DIV_LSB       = 19;
    localparam int MASTER_ENABLE_BIT    = 18;
    localparam int MASTER_SRC_BIT       = 16;
    localparam int SERIAL_SRC_BIT       = 12;
    localparam int FRAME_IN_INV_BIT     = 11;

    // Reset value and the bits that software can change.
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'hFFFD_1800;

    // Status register field positions.
    localparam int STAT_MASTER_BIT = 0;
    localparam int STAT_SERIAL_BIT = 1;
    localparam int STAT_ENABLE_BIT = 2;
    localparam int STAT_FRAME_BIT  = 3;

    // Divider field width.
    localparam int DIV_FIELD_WIDTH = 5;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Source selections.
    localparam logic SRC_GENERIC       = 1'h0;
    localparam logic SRC_MASTER_PIN    = 1'h1;
    localparam logic SRC_DIVIDED       = 1'h0;
    localparam logic SRC_SERIAL_PIN    = 1'h1;

    // Control register layout, most significant field first.
    typedef struct packed {
        logic       master_clock_out_invert;
        logic       serial_clock_out_invert;
        logic       frame_sync_out_invert;
        logic [4:0] master_out_divide_factor;
        logic [4:0] serial_divide_factor;
        logic       master_clock_enable;
        logic       reserved_17;
        logic       master_source_select;
        logic [2:0] reserved_15_13;
        logic       serial_source_select;
        logic       frame_sync_in_invert;
        logic [10:0] reserved_10_0;
    } ctrl_t;

endpackage : audio_clock_pkg

// file: clock_divider.sv
// Edge-counting divider that turns a sampled source clock into a divided clock level.
`timescale 1ns/10ps
module clock_divider #(
    parameter int WIDTH = 5
) (
    input  wire logic             aclk,      // System clock.
    input  wire logic             aresetn,   // Synchronous reset, active low.
    input  wire logic             enable,    // Divider runs while high.
    input  wire logic             src_level, // Sampled source clock level.
    input  wire logic             src_rise,  // One-cycle pulse at a source rising edge.
    input  wire logic [WIDTH-1:0] factor,    // Divide by factor plus one.
    output logic                  clk_out    // Divided clock level.
);
    import audio_clock_pkg::*;

    if (WIDTH < 1) begin : g_width_check
        $error("Divider needs a factor of at least one bit.");
    end

    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] next_cnt;
    logic [WIDTH:0]   half;

    // Wrap the count at the factor; the high phase is the first half of the period.
    // A count left above a newly lowered factor wraps at the next source rising edge instead of running to the top.
    assign next_cnt = (cnt >= factor) ? '0 : cnt + 1'b1;
    assign half     = ({1'b0, factor} + 1'b1) >> 1;

    // Clearing count and level to zero while disabled gives a clean first phase on enable.
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            cnt     <= '0;
            clk_out <= 1'b0;
        end else if (factor == '0) begin
            clk_out <= src_level;
        end else if (src_rise) begin
            cnt     <= next_cnt;
            clk_out <= ({1'b0, next_cnt} < half);
        end
    end

endmodule : clock_divider

// file: audio_serial_clock_unit.sv
// Audio serial clock unit: source selection, dividers, inversions and AXI4-Lite registers.
`timescale 1ns/10ps
// Notes on behaviour
// - Invert master clock output when bit 31 set.
// - Invert serial clock output when bit 30 set.
// - Invert frame sync output when bit 29 set.
// - Master output divides source by field plus one.
// - Serial clock divides master clock by field plus one.
// - Enable bit zero stops division and output.
// - Bit 16 picks generic clock or pin.
// - Bit 12 picks divided clock or pin.
// - Invert incoming frame sync when bit 11 set.
module audio_serial_clock_unit #(
    parameter int DIV_WIDTH = audio_clock_pkg::DIV_FIELD_WIDTH
) (
    input  wire logic        aclk,                // System clock, 125 MHz.
    input  wire logic        aresetn,             // Synchronous reset, active low.
    input  wire logic [3:0]  s_axi_awaddr,        // Write address.
    input  wire logic        s_axi_awvalid,       // Write address valid.
    output logic             s_axi_awready,       // Write address ready.
    input  wire logic [31:0] s_axi_wdata,         // Write data.
    input  wire logic [3:0]  s_axi_wstrb,         // Write byte strobes.
    input  wire logic        s_axi_wvalid,        // Write data valid.
    output logic             s_axi_wready,        // Write data ready.
    output logic [1:0]       s_axi_bresp,         // Write response.
    output logic             s_axi_bvalid,        // Write response valid.
    input  wire logic        s_axi_bready,        // Write response ready.
    input  wire logic [3:0]  s_axi_araddr,        // Read address.
    input  wire logic        s_axi_arvalid,       // Read address valid.
    output logic             s_axi_arready,       // Read address ready.
    output logic [31:0]      s_axi_rdata,         // Read data.
    output logic [1:0]       s_axi_rresp,         // Read response.
    output logic             s_axi_rvalid,        // Read data valid.
    input  wire logic        s_axi_rready,        // Read data ready.
    input  wire logic        audio_generic_clock, // Internal generic clock level.
    input  wire logic        master_clock_pin_i,  // Master clock pin, input side.
    output logic             master_clock_pin_o,  // Master clock pin, output side.
    output logic             master_clock_pin_oe, // Master clock pin driven when high.
    input  wire logic        serial_clock_pin_i,  // Serial clock pin, input side.
    output logic             serial_clock_pin_o,  // Serial clock pin, output side.
    output logic             serial_clock_pin_oe, // Serial clock pin driven when high.
    input  wire logic        frame_sync_gen,      // Frame sync from the frame engine.
    output logic             frame_sync_pin_o,    // Frame sync toward the pin.
    input  wire logic        frame_sync_pin_i,    // Frame sync from the pin.
    output logic             frame_sync_used,     // Frame sync as the engine uses it.
    output logic             serial_clock         // Serial clock as the engine uses it.
);
    import audio_clock_pkg::*;

    if (DIV_WIDTH != DIV_FIELD_WIDTH) begin : g_width_check
        $error("Divider width must match the five-bit control fields.");
    end

    ctrl_t                ctrl;
    logic [31:0]          ctrl_bits;
    logic [31:0]          next_ctrl;
    logic [31:0]          status_bits;
    logic                 aw_held;
    logic                 w_held;
    logic [3:0]           aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 wr_fire;
    logic                 wr_hit;
    logic                 rd_fire;
    logic [31:0]          rd_value;
    logic                 rd_ok;
    logic                 enable;
    logic                 master_src;
    logic                 master_prev;
    logic                 master_rise;
    logic                 master_div;
    logic                 serial_div;

    // Write channel: address and data are caught in either order, answered together.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit        = (aw_addr == CTRL_OFFSET) || (aw_addr == STATUS_OFFSET);
    assign ctrl_bits     = ctrl;

    // Byte strobes merge per lane; reserved bits stay zero through the mask.
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign next_ctrl[8*i+7:8*i] = w_strb[i] ? (w_data[8*i+7:8*i] & CTRL_WRITE_MASK[8*i+7:8*i])
                                                : ctrl_bits[8*i+7:8*i];
    end

    // Address and data holding registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // Control register and write response; the status word ignores writes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl         <= CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            if (aw_addr == CTRL_OFFSET) begin
                ctrl <= next_ctrl;
            end
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel: one read at a time, unmapped addresses answer with an error.
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign rd_ok         = (s_axi_araddr == CTRL_OFFSET) || (s_axi_araddr == STATUS_OFFSET);
    assign rd_value      = (s_axi_araddr == CTRL_OFFSET) ? ctrl_bits :
                           (s_axi_araddr == STATUS_OFFSET) ? status_bits : 32'h0000_0000;
    assign status_bits   = {28'h000_0000, frame_sync_used, enable, serial_clock,
                            master_clock_pin_o};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Source selection and edge detection of the selected master clock.
    assign enable      = ctrl.master_clock_enable;
    assign master_src  = (ctrl.master_source_select == SRC_MASTER_PIN) ?
                         master_clock_pin_i : audio_generic_clock;
    assign master_rise = master_src && !master_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_prev <= 1'b0;
        end else begin
            master_prev <= master_src;
        end
    end

    // Both dividers count the same master edges, so they stay phase related.
    clock_divider #(.WIDTH(DIV_WIDTH)) u_master_div (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .enable    (enable),
        .src_level (master_src),
        .src_rise  (master_rise),
        .factor    (ctrl.master_out_divide_factor),
        .clk_out   (master_div)
    );

    clock_divider #(.WIDTH(DIV_WIDTH)) u_serial_div (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .enable    (enable),
        .src_level (master_src),
        .src_rise  (master_rise),
        .factor    (ctrl.serial_divide_factor),
        .clk_out   (serial_div)
    );

    // Pin drivers; an input-selected pin is never driven, so no contention with the source.
    assign master_clock_pin_oe = enable && (ctrl.master_source_select == SRC_GENERIC);
    assign serial_clock_pin_oe = (ctrl.serial_source_select == SRC_DIVIDED);

    // Registered outputs cost one cycle of latency but keep the pins glitch free.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_clock_pin_o <= 1'b0;
            serial_clock_pin_o <= 1'b0;
            serial_clock       <= 1'b0;
            frame_sync_pin_o   <= 1'b0;
            frame_sync_used    <= 1'b0;
        end else begin
            master_clock_pin_o <= enable && (master_div ^ ctrl.master_clock_out_invert);
            serial_clock       <= (ctrl.serial_source_select == SRC_SERIAL_PIN) ?
                                  serial_clock_pin_i : serial_div;
            serial_clock_pin_o <= serial_div ^ ctrl.serial_clock_out_invert;
            frame_sync_pin_o   <= frame_sync_gen ^ ctrl.frame_sync_out_invert;
            frame_sync_used    <= frame_sync_pin_i ^ ctrl.frame_sync_in_invert;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    mck_pin_level_a: assert property ($past(enable) |-> master_clock_pin_o ==
        ($past(master_div) ^ $past(ctrl.master_clock_out_invert)))
        else $error("Master clock pin level does not follow divider and invert bit.");
    sck_pin_level_a: assert property (serial_clock_pin_o ==
        ($past(serial_div) ^ $past(ctrl.serial_clock_out_invert)))
        else $error("Serial clock pin level does not follow divider and invert bit.");
    fs_out_level_a: assert property (frame_sync_pin_o ==
        ($past(frame_sync_gen) ^ $past(ctrl.frame_sync_out_invert)))
        else $error("Frame sync output does not follow invert bit.");
    mck_div_edge_a: assert property ((enable && $past(enable) &&
        ctrl.master_out_divide_factor != 5'h00 && $stable(ctrl) && !$past(master_rise))
        |-> $stable(master_div))
        else $error("Master divider changed without a source edge.");
    sck_div_edge_a: assert property ((enable && $past(enable) &&
        ctrl.serial_divide_factor != 5'h00 && $stable(ctrl) && !$past(master_rise))
        |-> $stable(serial_div))
        else $error("Serial divider changed without a source edge.");
    mck_disabled_a: assert property (!enable |-> !master_clock_pin_oe ##1
        !master_clock_pin_o)
        else $error("Master clock pin active while disabled.");
    msrc_select_a: assert property (master_src == (ctrl.master_source_select ?
        master_clock_pin_i : audio_generic_clock))
        else $error("Master source does not match select bit.");
    sck_select_a: assert property ($past(ctrl.serial_source_select) |->
        serial_clock == $past(serial_clock_pin_i))
        else $error("Serial clock does not follow its pin when selected.");
    fs_in_inv_a: assert property (frame_sync_used ==
        ($past(frame_sync_pin_i) ^ $past(ctrl.frame_sync_in_invert)))
        else $error("Used frame sync does not follow invert bit.");
    div_hold_a: assert property (!enable [*2] |-> !master_div && !serial_div)
        else $error("Dividers not held while disabled.");

    enable_rise_c: cover property ($rose(enable));
    pin_source_c:  cover property (enable && ctrl.master_source_select && $rose(master_div));
    serial_pin_c:  cover property (ctrl.serial_source_select && $rose(serial_clock));
    divided_c:     cover property (enable && ctrl.master_out_divide_factor == 5'h03 &&
                                   $rose(master_div));

endmodule : audio_serial_clock_unit

// file: codec_partner.sv
// Behavioural model of the external codec that drives the clock and frame sync pins.
`timescale 1ns/10ps
module codec_partner (
    input  wire logic       aclk,        // System clock.
    input  wire logic       run_master,  // Master pin clock runs while high.
    input  wire logic       run_serial,  // Serial pin clock runs while high.
    input  wire logic [7:0] half_master, // Master pin half period in cycles.
    input  wire logic [7:0] half_serial, // Serial pin half period in cycles.
    input  wire logic       fs_level,    // Frame sync level to present.
    input  wire logic       mck_o,       // Device side of the master pin.
    input  wire logic       mck_oe,      // Device drives the master pin.
    input  wire logic       sck_o,       // Device side of the serial pin.
    input  wire logic       sck_oe,      // Device drives the serial pin.
    output logic            mck_wire,    // Resolved master pin level.
    output logic            sck_wire,    // Resolved serial pin level.
    output logic            fs_wire      // Frame sync pin level.
);
    logic [7:0] cnt_m = 8'h00;
    logic [7:0] cnt_s = 8'h00;
    logic       own_m = 1'b0;
    logic       own_s = 1'b0;
    // An idle codec holds its clocks low, so nothing toggles outside a run.
    always @(posedge aclk) begin
        if (!run_master || cnt_m == half_master - 8'h01) begin
            cnt_m <= 8'h00;
            own_m <= run_master ? ~own_m : 1'b0;
        end else begin
            cnt_m <= cnt_m + 8'h01;
        end
        if (!run_serial || cnt_s == half_serial - 8'h01) begin
            cnt_s <= 8'h00;
            own_s <= run_serial ? ~own_s : 1'b0;
        end else begin
            cnt_s <= cnt_s + 8'h01;
        end
    end
    // The device wins the pin while it enables its driver.
    assign mck_wire = mck_oe ? mck_o : own_m;
    assign sck_wire = sck_oe ? sck_o : own_s;
    assign fs_wire  = fs_level;
endmodule : codec_partner

// file: tb_audio_serial_clock_unit.sv
// Self-checking testbench of the audio serial clock unit.
`timescale 1ns/10ps
module tb_audio_serial_clock_unit;
    import audio_clock_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, gen_clk = 1'b0, gen_run = 1'b0, gen_lvl = 1'b0, gc = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_bvalid;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_rvalid;
    logic s_axi_awready, s_axi_wready, s_axi_arready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic mck_i, mck_o, mck_oe, sck_i, sck_o, sck_oe, fs_gen = 1'b0, fs_pin_o, fs_i, fs_used;
    logic serial_clock, run_m = 1'b0, run_s = 1'b0, fs_lvl = 1'b0;
    int error_cnt = 0, checks_done = 0;

    always #4 aclk = ~aclk;
    // Generic clock toggles every second cycle while running, else holds a static level.
    always @(posedge aclk) begin
        gc <= ~gc;
        gen_clk <= gen_run ? (gc ? ~gen_clk : gen_clk) : gen_lvl;
    end

    audio_serial_clock_unit u_audio_serial_clock_unit (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .audio_generic_clock(gen_clk),
        .master_clock_pin_i(mck_i), .master_clock_pin_o(mck_o), .master_clock_pin_oe(mck_oe),
        .serial_clock_pin_i(sck_i), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
        .frame_sync_gen(fs_gen), .frame_sync_pin_o(fs_pin_o), .frame_sync_pin_i(fs_i),
        .frame_sync_used(fs_used), .serial_clock(serial_clock));

    codec_partner u_codec_partner (.aclk(aclk), .run_master(run_m), .run_serial(run_s),
        .half_master(8'h03), .half_serial(8'h05), .fs_level(fs_lvl), .mck_o(mck_o),
        .mck_oe(mck_oe), .sck_o(sck_o), .sck_oe(sck_oe), .mck_wire(mck_i), .sck_wire(sck_i),
        .fs_wire(fs_i));

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen 0x%08h expected 0x%08h", $time, seen, exp);
        end
    endtask : check

    // A wait that runs out counts as a mismatch and ends the run.
    task automatic expire();
        check(32'h0, 32'h1);
        end_of_test();
    endtask : expire

    function automatic logic [31:0] cfg(input logic [2:0] inv, input logic [4:0] md,
        input logic [4:0] sd, input logic en, input logic ms, input logic ss, input logic fi);
        cfg = {inv, md, sd, en, 1'b0, ms, 3'h0, ss, fi, 11'h000};
    endfunction : cfg

    // Both channels are offered together; an edge passes at the end so strobes never collide.
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw_done, w_done, b_done;
        n = 0; aw_done = 1'b0; w_done = 1'b0; b_done = 1'b0;
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk); n++;
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin w_done = 1'b1; s_axi_wvalid <= 1'b0; end
            if (s_axi_bvalid === 1'b1) begin
                b_done = 1'b1;
                s_axi_bready <= 1'b0;
                check(32'(s_axi_bresp), 32'(er));
            end
        end while (!b_done && n < 50);
        if (!b_done) expire();
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ar_done, r_done;
        n = 0; ar_done = 1'b0; r_done = 1'b0; d = 32'h0; r = 2'h0;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk); n++;
            if (!ar_done && s_axi_arready === 1'b1) begin
                ar_done = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                r_done = 1'b1; d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0;
            end
        end while (!r_done && n < 50);
        if (!r_done) expire();
        @(posedge aclk);
    endtask : axi_read

    // Period from the second to the third rising edge, so a partial first cycle is skipped.
    task automatic measure(input logic sel, input int exp);
        int n, t0, rises;
        logic prev, cur;
        n = 0; t0 = 0; rises = 0; prev = sel ? serial_clock : mck_o;
        while (rises < 3 && n < 1000) begin
            @(posedge aclk); n++;
            cur = sel ? serial_clock : mck_o;
            if (cur === 1'b1 && prev === 1'b0) begin rises++; if (rises == 2) t0 = n; end
            prev = cur;
        end
        if (rises < 3) expire();
        check(32'(n - t0), 32'(exp));
    endtask : measure

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_read(CTRL_OFFSET, d, r);
        check(d, CTRL_RESET);
        axi_write(CTRL_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
        axi_read(CTRL_OFFSET, d, r);
        check(d, CTRL_WRITE_MASK);
        axi_write(4'h8, 32'h0, RESP_SLVERR);
        axi_read(4'h8, d, r);
        check({r, d[29:0]}, {RESP_SLVERR, 30'h0});
        s_axi_wstrb <= 4'h8;
        axi_write(CTRL_OFFSET, 32'h0000_0000, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axi_write(STATUS_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
        axi_read(CTRL_OFFSET, d, r);
        check(d, CTRL_WRITE_MASK & 32'h00FF_FFFF);
        axi_write(CTRL_OFFSET, CTRL_RESET, RESP_OKAY);
        $display("t_regs done");
    endtask : t_regs

    // Static source levels keep the pass-through latency out of the inversion checks.
    task automatic t_invert();
        logic lvl, inv, fi;
        logic [31:0] d;
        logic [1:0] r;
        for (int k = 0; k < 8; k++) begin
            lvl = k[0]; inv = k[1]; fi = k[2];
            gen_lvl <= lvl; fs_gen <= lvl; fs_lvl <= lvl;
            axi_write(CTRL_OFFSET, cfg({3{inv}}, 5'h00, 5'h00, 1'b1, SRC_GENERIC, SRC_DIVIDED, fi),
                      RESP_OKAY);
            repeat (8) @(posedge aclk);
            check(32'(mck_o), 32'(lvl ^ inv));
            check(32'(sck_o), 32'(lvl ^ inv));
            check(32'(fs_pin_o), 32'(lvl ^ inv));
            check(32'(fs_used), 32'(lvl ^ fi));
            check(32'(mck_oe), 32'h1);
            axi_read(STATUS_OFFSET, d, r);
            check({r, d[29:0]}, {RESP_OKAY, 26'h0, lvl ^ fi, 1'b1, lvl, lvl ^ inv});
        end
        $display("t_invert done");
    endtask : t_invert

    task automatic t_divide();
        logic [4:0] md[3] = '{5'h03, 5'h02, 5'h1F};
        logic [4:0] sd[3] = '{5'h03, 5'h00, 5'h01};
        gen_run <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            axi_write(CTRL_OFFSET, cfg(3'h0, md[k], sd[k], 1'b1, SRC_GENERIC, SRC_DIVIDED, 1'b0),
                      RESP_OKAY);
            measure(1'b0, 4 * (int'(md[k]) + 1));
            measure(1'b1, 4 * (int'(sd[k]) + 1));
        end
        $display("t_divide done");
    endtask : t_divide

    task automatic t_disable();
        axi_write(CTRL_OFFSET, cfg(3'h4, 5'h01, 5'h01, 1'b0, SRC_GENERIC, SRC_DIVIDED, 1'b0),
                  RESP_OKAY);
        repeat (4) @(posedge aclk);
        for (int k = 0; k < 40; k++) begin
            @(posedge aclk);
            check(32'({mck_o, mck_oe}), 32'h0);
            check(32'({serial_clock, sck_o}), 32'h0);
        end
        axi_write(CTRL_OFFSET, cfg(3'h0, 5'h01, 5'h01, 1'b1, SRC_GENERIC, SRC_DIVIDED, 1'b0),
                  RESP_OKAY);
        measure(1'b0, 8);
        $display("t_disable done");
    endtask : t_disable

    task automatic t_pins();
        run_m <= 1'b1;
        axi_write(CTRL_OFFSET, cfg(3'h0, 5'h00, 5'h01, 1'b1, SRC_MASTER_PIN, SRC_DIVIDED, 1'b0),
                  RESP_OKAY);
        check(32'(mck_oe), 32'h0);
        measure(1'b1, 12);
        run_s <= 1'b1;
        axi_write(CTRL_OFFSET, cfg(3'h0, 5'h00, 5'h01, 1'b1, SRC_MASTER_PIN, SRC_SERIAL_PIN,
                  1'b0), RESP_OKAY);
        check(32'(sck_oe), 32'h0);
        measure(1'b1, 10);
        $display("t_pins done");
    endtask : t_pins

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_invert();
        t_divide();
        t_disable();
        t_pins();
        end_of_test();
    end
endmodule : tb_audio_serial_clock_unit
